// ==== src/uart_char_fifo.sv ====
// character buffer, DEPTH deep or one entry
// assumes one clock
`timescale 1ns/100ps

module uart_char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             single_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } ff_st_t;

    ff_st_t st_ff;
    ff_st_t nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : ptr_inc

    // single mode holds one character only
    assign in_ready_out  = single_in ? (st_ff.count == '0) : (st_ff.count != (AW+1)'(DEPTH));
    assign out_valid_out = (st_ff.count != '0);
    assign out_data_out  = mem[st_ff.rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr_ptr = ptr_inc(st_ff.wr_ptr);
        end
        if (pop) begin
            nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
        end
        if (push && !pop) begin
            nxt_st.count = (AW+1)'(st_ff.count + 1'b1);
        end else if (pop && !push) begin
            nxt_st.count = (AW+1)'(st_ff.count - 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[st_ff.wr_ptr] <= in_data_in;
        end
    end

endmodule : uart_char_fifo

// ==== src/uart_lc_defs.svh ====
// offsets, field positions, reset values, timing counts
// assumes byte addresses, one 32-bit word per register
`ifndef UART_LC_DEFS_SVH
`define UART_LC_DEFS_SVH

`define ULC_OFS_DATA 8'h00
`define ULC_OFS_STATUS 8'h04
`define ULC_OFS_IBRD 8'h08
`define ULC_OFS_FBRD 8'h0c
`define ULC_OFS_LCR 8'h10
`define ULC_OFS_CR 8'h14

`define ULC_LCR_BRK 0
`define ULC_LCR_PEN 1
`define ULC_LCR_EPS 2
`define ULC_LCR_TWO_STOP_SELECT 3
`define ULC_LCR_FEN 4
`define ULC_LCR_WORD_LENGTH_SEL_LO 5
`define ULC_LCR_WORD_LENGTH_SEL_HI 6
`define ULC_LCR_SPS 7

`define ULC_CR_UARTEN 0
`define ULC_CR_TXE 8
`define ULC_CR_RXE 9
`define ULC_CR_MASK 16'hcf07

`define ULC_ST_BUSY 0
`define ULC_ST_RX_EMPTY 1
`define ULC_ST_TX_FULL 2
`define ULC_ST_RX_FULL 3
`define ULC_ST_TX_EMPTY 4
`define ULC_ST_OVERRUN 5

`define ULC_LCR_RST 8'h00
`define ULC_CR_RST 16'h0000
`define ULC_IBRD_RST 16'h0000
`define ULC_FBRD_RST 6'h00

`define ULC_OVS_LAST 4'hf
`define ULC_OVS_MID 4'h7
`define ULC_FRAC_ONE 22'h000040

`endif

// ==== src/uart_lc_pkg.sv ====
// state types
// assumes nothing
package uart_lc_pkg;

    typedef enum logic [2:0] {
        tx_idle   = 3'h0,
        tx_start  = 3'h1,
        tx_data   = 3'h3,
        tx_parity = 3'h2,
        tx_stop   = 3'h6
    } tx_state_t;

    typedef enum logic [2:0] {
        rx_idle   = 3'h0,
        rx_start  = 3'h1,
        rx_data   = 3'h3,
        rx_parity = 3'h2,
        rx_stop   = 3'h6
    } rx_state_t;

endpackage : uart_lc_pkg

// ==== src/uart_line_control.sv ====
// serial port: frame format, break, divisor commit
// assumes one-cycle strobes, 100 MHz clock
`timescale 1ns/100ps
`include "uart_lc_defs.svh"

// How it works
// - stick, even, parity set: parity sent and checked as 0.
// - stick, parity set, even clear: parity sent and checked as 1.
// - stick clear: plain even or odd parity.
// - length code 00..11 gives five to eight data bits.
// - fifo select 1: both buffers are fifos.
// - fifo select 0: each buffer holds one byte.
// - two stop select 1 sends two stop bits, else one.
// - receiver checks only the first stop bit.
// - even select 1: even count of ones over data and parity.
// - even select 0: odd count of ones over data and parity.
// - even and stick selects do nothing while parity is off.
// - parity enable adds and checks a parity bit.
// - send break holds the line low after the current character.
// - break leaves the transmit fifo contents untouched.
// - divisor is clock over sixteen times baud, 16.6 fixed point.
module uart_line_control #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    input  wire logic        rxd_in,
    output logic             txd_out
);

    typedef struct packed {
        logic [7:0]              lcr;
        logic [15:0]             cr;
        logic [15:0]             ibrd;
        logic [5:0]              fbrd;
        logic [31:0]             rdata;
        logic                    overrun;
        logic [2:0]              rx_sync;
        logic                    rx_level;
        uart_lc_pkg::tx_state_t  tx_state;
        logic [3:0]              tx_tick;
        logic [2:0]              tx_bit;
        logic [7:0]              tx_shift;
        logic                    tx_par;
        logic                    tx_stop_cnt;
        logic                    txd;
        uart_lc_pkg::rx_state_t  rx_state;
        logic [3:0]              rx_tick;
        logic [2:0]              rx_bit;
        logic [7:0]              rx_shift;
        logic                    rx_ones;
        logic                    rx_perr;
        logic                    rx_armed;
        logic                    rx_push;
        logic [10:0]             rx_word;
    } st_t;

    st_t         s_ff;
    st_t         nxt_s;
    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic        tick;
    logic        lcr_load;
    logic        tx_valid;
    logic        tx_in_ready;
    logic        tx_pop_ready;
    logic [7:0]  tx_char;
    logic        rx_valid;
    logic        rx_in_ready;
    logic [10:0] rx_char;
    logic        tx_en;
    logic        rx_en;
    logic        pen;
    logic [1:0]  word_length_sel;
    logic [2:0]  last_bit;
    logic [7:0]  rx_aligned;

    function automatic logic [2:0] last_idx(input logic [1:0] wl);
        last_idx = 3'(3'd4 + {1'b0, wl});
    endfunction : last_idx

    function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr);
        logic [7:0] m;
        m = 8'hff >> (2'd3 - lcr[`ULC_LCR_WORD_LENGTH_SEL_HI:`ULC_LCR_WORD_LENGTH_SEL_LO]);
        if (lcr[`ULC_LCR_SPS]) begin
            par_bit = !lcr[`ULC_LCR_EPS];
        end else if (lcr[`ULC_LCR_EPS]) begin
            par_bit = ^(d & m);
        end else begin
            par_bit = ~^(d & m);
        end
    endfunction : par_bit

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign lcr_load = wr_in && (addr_in == `ULC_OFS_LCR);

    uart_rate_gen u_rate_gen (
        .clk_in      (core_clk_in),
        .rst_n_in    (rst_n),
        .load_in     (lcr_load),
        .int_div_in  (s_ff.ibrd),
        .frac_div_in (s_ff.fbrd),
        .tick_out    (tick)
    );

    assign tx_en = s_ff.cr[`ULC_CR_UARTEN] && s_ff.cr[`ULC_CR_TXE];
    assign rx_en = s_ff.cr[`ULC_CR_UARTEN] && s_ff.cr[`ULC_CR_RXE];
    assign pen = s_ff.lcr[`ULC_LCR_PEN];
    assign word_length_sel = s_ff.lcr[`ULC_LCR_WORD_LENGTH_SEL_HI:`ULC_LCR_WORD_LENGTH_SEL_LO];
    assign last_bit = last_idx(word_length_sel);
    assign rx_aligned = s_ff.rx_shift >> (3'd7 - last_bit);
    // break stalls the pop, queue kept
    assign tx_pop_ready = tick && (s_ff.tx_state == uart_lc_pkg::tx_idle) && tx_en
                          && !s_ff.lcr[`ULC_LCR_BRK];

    uart_char_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in        (core_clk_in),
        .rst_n_in      (rst_n),
        .single_in     (!s_ff.lcr[`ULC_LCR_FEN]),
        .in_valid_in   (wr_in && (addr_in == `ULC_OFS_DATA)),
        .in_ready_out  (tx_in_ready),
        .in_data_in    (wdata_in[7:0]),
        .out_valid_out (tx_valid),
        .out_ready_in  (tx_pop_ready),
        .out_data_out  (tx_char)
    );

    uart_char_fifo #(
        .WIDTH (11),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in        (core_clk_in),
        .rst_n_in      (rst_n),
        .single_in     (!s_ff.lcr[`ULC_LCR_FEN]),
        .in_valid_in   (s_ff.rx_push),
        .in_ready_out  (rx_in_ready),
        .in_data_in    (s_ff.rx_word),
        .out_valid_out (rx_valid),
        .out_ready_in  (rd_in && (addr_in == `ULC_OFS_DATA)),
        .out_data_out  (rx_char)
    );

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rx_push = 1'b0;
        nxt_s.rdata = 32'h00000000;
        // rx sync, moves when stages two and three agree
        nxt_s.rx_sync = {s_ff.rx_sync[1:0], rxd_in};
        if (s_ff.rx_sync[1] == s_ff.rx_sync[2]) begin
            nxt_s.rx_level = s_ff.rx_sync[2];
        end

        if (wr_in) begin
            unique case (addr_in)
                `ULC_OFS_IBRD: nxt_s.ibrd = wdata_in[15:0];
                `ULC_OFS_FBRD: nxt_s.fbrd = wdata_in[5:0];
                `ULC_OFS_LCR: nxt_s.lcr = wdata_in[7:0];
                `ULC_OFS_CR: nxt_s.cr = wdata_in[15:0] & `ULC_CR_MASK;
                `ULC_OFS_STATUS: nxt_s.overrun = 1'b0;
                default: ;
            endcase
        end

        // register reads, data in the next cycle
        if (rd_in) begin
            unique case (addr_in)
                `ULC_OFS_DATA: nxt_s.rdata = {20'h00000, s_ff.overrun, rx_valid ? rx_char : 11'h000};
                `ULC_OFS_STATUS: begin
                    nxt_s.rdata[`ULC_ST_BUSY] = (s_ff.tx_state != uart_lc_pkg::tx_idle);
                    nxt_s.rdata[`ULC_ST_RX_EMPTY] = !rx_valid;
                    nxt_s.rdata[`ULC_ST_TX_FULL] = !tx_in_ready;
                    nxt_s.rdata[`ULC_ST_RX_FULL] = !rx_in_ready;
                    nxt_s.rdata[`ULC_ST_TX_EMPTY] = !tx_valid;
                    nxt_s.rdata[`ULC_ST_OVERRUN] = s_ff.overrun;
                end
                `ULC_OFS_IBRD: nxt_s.rdata = {16'h0000, s_ff.ibrd};
                `ULC_OFS_FBRD: nxt_s.rdata = {26'h0000000, s_ff.fbrd};
                `ULC_OFS_LCR: nxt_s.rdata = {24'h000000, s_ff.lcr};
                `ULC_OFS_CR: nxt_s.rdata = {16'h0000, s_ff.cr};
                default: ;
            endcase
        end

        // overrun set wins over a clear
        if (s_ff.rx_push && !rx_in_ready) begin
            nxt_s.overrun = 1'b1;
        end

        // transmitter, sixteen ticks a bit
        if (tick) begin
            nxt_s.tx_tick = 4'(s_ff.tx_tick + 1'b1);
            unique case (s_ff.tx_state)
                uart_lc_pkg::tx_idle: begin
                    nxt_s.txd = !s_ff.lcr[`ULC_LCR_BRK];
                    if (tx_pop_ready && tx_valid) begin
                        nxt_s.tx_state = uart_lc_pkg::tx_start;
                        nxt_s.tx_shift = tx_char;
                        nxt_s.tx_par = par_bit(tx_char, s_ff.lcr);
                        nxt_s.tx_tick = 4'h0;
                        nxt_s.tx_stop_cnt = 1'b0;
                        nxt_s.txd = 1'b0;
                    end
                end
                uart_lc_pkg::tx_start: begin
                    if (s_ff.tx_tick == `ULC_OVS_LAST) begin
                        nxt_s.tx_state = uart_lc_pkg::tx_data;
                        nxt_s.tx_bit = 3'h0;
                        nxt_s.txd = s_ff.tx_shift[0];
                    end
                end
                uart_lc_pkg::tx_data: begin
                    if (s_ff.tx_tick == `ULC_OVS_LAST) begin
                        nxt_s.tx_shift = {1'b0, s_ff.tx_shift[7:1]};
                        nxt_s.tx_bit = 3'(s_ff.tx_bit + 1'b1);
                        nxt_s.txd = s_ff.tx_shift[1];
                        if (s_ff.tx_bit == last_bit) begin
                            if (pen) begin
                                nxt_s.tx_state = uart_lc_pkg::tx_parity;
                                nxt_s.txd = s_ff.tx_par;
                            end else begin
                                nxt_s.tx_state = uart_lc_pkg::tx_stop;
                                nxt_s.txd = 1'b1;
                            end
                        end
                    end
                end
                uart_lc_pkg::tx_parity: begin
                    if (s_ff.tx_tick == `ULC_OVS_LAST) begin
                        nxt_s.tx_state = uart_lc_pkg::tx_stop;
                        nxt_s.txd = 1'b1;
                    end
                end
                uart_lc_pkg::tx_stop: begin
                    if (s_ff.tx_tick == `ULC_OVS_LAST) begin
                        if (s_ff.lcr[`ULC_LCR_TWO_STOP_SELECT] && !s_ff.tx_stop_cnt) begin
                            nxt_s.tx_stop_cnt = 1'b1;
                        end else begin
                            nxt_s.tx_state = uart_lc_pkg::tx_idle;
                            nxt_s.txd = !s_ff.lcr[`ULC_LCR_BRK];
                        end
                    end
                end
            endcase

            // receiver, start rechecked at mid-bit
            nxt_s.rx_tick = 4'(s_ff.rx_tick + 1'b1);
            unique case (s_ff.rx_state)
                uart_lc_pkg::rx_idle: begin
                    if (s_ff.rx_level) begin
                        nxt_s.rx_armed = 1'b1;
                    end else if (s_ff.rx_armed && rx_en) begin
                        nxt_s.rx_state = uart_lc_pkg::rx_start;
                        nxt_s.rx_tick = 4'h0;
                    end
                end
                uart_lc_pkg::rx_start: begin
                    if (s_ff.rx_tick == `ULC_OVS_MID) begin
                        nxt_s.rx_tick = 4'h0;
                        nxt_s.rx_bit = 3'h0;
                        nxt_s.rx_ones = 1'b0;
                        nxt_s.rx_perr = 1'b0;
                        nxt_s.rx_state = s_ff.rx_level ? uart_lc_pkg::rx_idle : uart_lc_pkg::rx_data;
                    end
                end
                uart_lc_pkg::rx_data: begin
                    if (s_ff.rx_tick == `ULC_OVS_LAST) begin
                        nxt_s.rx_shift = {s_ff.rx_level, s_ff.rx_shift[7:1]};
                        nxt_s.rx_ones = s_ff.rx_ones | s_ff.rx_level;
                        nxt_s.rx_bit = 3'(s_ff.rx_bit + 1'b1);
                        if (s_ff.rx_bit == last_bit) begin
                            nxt_s.rx_state = pen ? uart_lc_pkg::rx_parity : uart_lc_pkg::rx_stop;
                        end
                    end
                end
                uart_lc_pkg::rx_parity: begin
                    if (s_ff.rx_tick == `ULC_OVS_LAST) begin
                        nxt_s.rx_ones = s_ff.rx_ones | s_ff.rx_level;
                        nxt_s.rx_perr = (s_ff.rx_level != par_bit(rx_aligned, s_ff.lcr));
                        nxt_s.rx_state = uart_lc_pkg::rx_stop;
                    end
                end
                uart_lc_pkg::rx_stop: begin
                    if (s_ff.rx_tick == `ULC_OVS_LAST) begin
                        nxt_s.rx_push = 1'b1;
                        nxt_s.rx_word = {!s_ff.rx_ones && !s_ff.rx_level, s_ff.rx_perr,
                                         !s_ff.rx_level, rx_aligned};
                        nxt_s.rx_armed = s_ff.rx_level;
                        nxt_s.rx_state = uart_lc_pkg::rx_idle;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
            s_ff.lcr <= `ULC_LCR_RST;
            s_ff.cr <= `ULC_CR_RST;
            s_ff.ibrd <= `ULC_IBRD_RST;
            s_ff.fbrd <= `ULC_FBRD_RST;
            s_ff.rx_sync <= 3'h7;
            s_ff.rx_level <= 1'b1;
            s_ff.txd <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rdata_out = s_ff.rdata;
    assign txd_out = s_ff.txd;

endmodule : uart_line_control

// ==== src/uart_rate_gen.sv ====
// 16x tick generator, 6-bit fraction
// assumes load_in is a one-cycle pulse
`timescale 1ns/100ps
`include "uart_lc_defs.svh"

module uart_rate_gen (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        load_in,
    input  wire logic [15:0] int_div_in,
    input  wire logic [5:0]  frac_div_in,
    output logic             tick_out
);

    typedef struct packed {
        logic [21:0] div;
        logic [21:0] acc;
        logic        tick;
    } rg_st_t;

    rg_st_t st_ff;
    rg_st_t nxt_st;
    logic [22:0] sum;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        sum = {1'b0, st_ff.acc} + {1'b0, `ULC_FRAC_ONE};
        if (load_in) begin
            nxt_st.div = {int_div_in, frac_div_in};
            nxt_st.acc = 22'h000000;
        end else if (st_ff.div != 22'h000000) begin
            if (sum >= {1'b0, st_ff.div}) begin
                nxt_st.acc = 22'(sum - {1'b0, st_ff.div});
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.acc = sum[21:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_out = st_ff.tick;

endmodule : uart_rate_gen

// ==== verif/serial_peer.sv ====
// remote device driving the receive line
// assumes 16 cycles a bit
`timescale 1ns/100ps

module serial_peer (
    input  wire logic clk_in,
    output logic      rxd_out
);
    initial rxd_out = 1'b1;

    // bit 0 first, line back to mark when done
    task automatic send(input logic [15:0] f);
        for (int i = 0; i < int'(f[15:12]); i++) begin
            @(posedge clk_in);
            rxd_out <= f[i];
            repeat (15) @(posedge clk_in);
        end
        @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask : send
endmodule : serial_peer

// ==== verif/uart_line_control_assertions.sv ====
// checker: register port and transmit line
// assumes one clock
`timescale 1ns/100ps
`include "uart_lc_defs.svh"

module uart_line_control_checker (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        rxd_in,
    input wire logic        txd_out
);
    logic [7:0]  lcr_ff;
    logic [15:0] ibrd_ff;
    logic [15:0] cr_ff;
    logic [5:0]  fbrd_ff;
    logic        zero_ff;
    logic        one_ff;
    logic [7:0]  low_ff;
    wire         wr_lcr = wr_in && addr_in == `ULC_OFS_LCR;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // shadows, committed divisor, low run length
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {lcr_ff, ibrd_ff, cr_ff, fbrd_ff, one_ff, low_ff} <= '0;
            zero_ff <= 1'b1;
        end else begin
            low_ff <= txd_out ? 8'h00 : low_ff + {7'h0, low_ff != 8'hff};
            if (wr_in && addr_in == `ULC_OFS_IBRD) ibrd_ff <= wdata_in[15:0];
            if (wr_in && addr_in == `ULC_OFS_FBRD) fbrd_ff <= wdata_in[5:0];
            if (wr_in && addr_in == `ULC_OFS_CR) cr_ff <= wdata_in[15:0];
            if (wr_lcr) lcr_ff <= wdata_in[7:0];
            if (wr_lcr) zero_ff <= {ibrd_ff, fbrd_ff} == 22'h0;
            if (wr_lcr) one_ff <= {ibrd_ff, fbrd_ff} == `ULC_FRAC_ONE;
        end
    end

    a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data without read");
    a_unmapped_zero: assert property (rd_in && addr_in == 8'h20 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_lcr_readback: assert property (rd_in && addr_in == `ULC_OFS_LCR |=> rdata_out == {24'h0, $past(lcr_ff)})
        else $error("line control readback");
    a_ibrd_readback: assert property (rd_in && addr_in == `ULC_OFS_IBRD |=> rdata_out[15:0] == $past(ibrd_ff))
        else $error("integer readback");
    a_fbrd_readback: assert property (rd_in && addr_in == `ULC_OFS_FBRD |=> rdata_out[5:0] == $past(fbrd_ff))
        else $error("fraction readback");
    a_cr_readback: assert property (rd_in && addr_in == `ULC_OFS_CR |=> rdata_out[15:0] == ($past(cr_ff) & `ULC_CR_MASK))
        else $error("port control readback");
    a_no_rate_idle: assert property (zero_ff && $past(zero_ff, 4) && !lcr_ff[0] && txd_out |=> txd_out)
        else $error("line moved, no divisor");
    a_low_span: assert property (one_ff && !lcr_ff[0] && !$past(lcr_ff[0], 6) |-> low_ff < 8'd170)
        else $error("line low too long");
endmodule : uart_line_control_checker

bind uart_line_control uart_line_control_checker u_chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd_in), .txd_out(txd_out)
);

// ==== verif/uart_line_control_tb.sv ====
// bench: registers, transmit frames, receive frames
// assumes divisor 1, 16 cycles a bit
`timescale 1ns/100ps
`include "uart_lc_defs.svh"

module uart_line_control_tb;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in    = 1'b0;
    logic [7:0]  addr_in     = 8'h00;
    logic [31:0] wdata_in    = 32'h0;
    logic        wr_in       = 1'b0;
    logic        rd_in       = 1'b0;
    logic [31:0] rdata_out;
    logic        rxd_in;
    logic        txd_out;
    logic        rd_seen     = 1'b0;
    logic        brk_on      = 1'b0;
    logic [7:0]  lcr_cur     = 8'h60;
    logic [31:0] rq[$];
    logic [15:0] fq[$];
    logic [7:0]  fmt[8]      = '{8'h10, 8'h32, 8'h56, 8'h7e, 8'hf2, 8'hf6, 8'hf4, 8'h38};
    int          err_count   = 0;
    int          checks      = 0;

    always #5 core_clk_in = ~core_clk_in;

    uart_line_control #(.FIFO_DEPTH(4)) u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd_in), .txd_out(txd_out));
    serial_peer u_peer (.clk_in(core_clk_in), .rxd_out(rxd_in));

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_frame(input logic [11:0] exp, input logic [11:0] got);
        chk_word("frame", {20'h0, exp}, {20'h0, got});
    endtask : chk_frame

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge core_clk_in);
        wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge core_clk_in);
        rd_in   <= 1'b0;
    endtask : rd

    // frame as {length, bits}, bit 0 is the start bit
    function automatic logic [15:0] mk(input logic [7:0] d, input logic [7:0] l);
        int          n;
        int          k;
        logic [11:0] b;
        logic [7:0]  m;
        n = 5 + int'(l[6:5]);
        m = d & 8'((1 << n) - 1);
        b = 12'h0;
        for (k = 0; k < n; k++) b[k + 1] = m[k];
        k = n + 1;
        if (l[`ULC_LCR_PEN]) begin
            b[k] = l[`ULC_LCR_SPS] ? ~l[`ULC_LCR_EPS] : (l[`ULC_LCR_EPS] ? ^m : ~^m);
            k++;
        end
        b[k] = 1'b1;
        if (l[`ULC_LCR_TWO_STOP_SELECT]) b[k + 1] = 1'b1;
        return {4'(k + 1 + int'(l[`ULC_LCR_TWO_STOP_SELECT])), b};
    endfunction : mk

    task automatic tx(input logic [7:0] d);
        fq.push_back(mk(d, lcr_cur));
        wr(`ULC_OFS_DATA, {24'h0, d});
    endtask : tx

    task automatic drain();
        for (int w = 0; w < 3000 && fq.size() > 0; w++) @(posedge core_clk_in);
        repeat (200) @(posedge core_clk_in);
    endtask : drain

    task automatic rxc(input logic [7:0] l, input logic flip, bad);
        logic [15:0] f;
        logic [7:0]  d;
        int          n;
        n = 5 + int'(l[6:5]);
        d = 8'($urandom) | 8'h01;
        f = mk(d, l);
        wr(`ULC_OFS_LCR, {24'h0, l});
        if (flip) f[n + 1] = ~f[n + 1];
        f[n + 1 + int'(l[1])] = ~bad;
        u_peer.send(f);
        repeat (8) @(posedge core_clk_in);
        rd(`ULC_OFS_DATA, {22'h0, flip, bad, d & 8'((1 << n) - 1)});
    endtask : rxc

    always @(posedge core_clk_in) begin
        if (rd_seen && rq.size() > 0) chk_word("read data", rq.pop_front(), rdata_out);
        rd_seen <= rd_in;
    end

    // tx watcher, empty queue gives a note that cannot match
    initial begin
        logic [15:0] e;
        logic [11:0] g;
        forever begin
            @(negedge txd_out iff !brk_on);
            e = fq.size() > 0 ? fq.pop_front() : 16'hc000;
            g = 12'h0;
            repeat (8) @(posedge core_clk_in);
            for (int k = 0; k < int'(e[15:12]); k++) begin
                g[k] = txd_out;
                if (k < int'(e[15:12]) - 1) repeat (16) @(posedge core_clk_in);
            end
            chk_frame(e[11:0], g);
        end
    end

    initial begin
        repeat (40000) @(posedge core_clk_in);
        err_count++;
        results();
    end

    initial begin
        void'($urandom(35));
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h0);
        rd(`ULC_OFS_LCR, 32'h0);
        rd(`ULC_OFS_FBRD, 32'h0);
        rd(`ULC_OFS_CR, 32'h0);
        $display("done: reset values");
        wr(`ULC_OFS_CR, 32'h301);
        wr(`ULC_OFS_IBRD, 32'h1);
        wr(`ULC_OFS_FBRD, 32'h0);
        wr(`ULC_OFS_DATA, 32'h55);
        repeat (300) @(posedge core_clk_in);
        chk_word("idle line", 32'h1, {31'h0, txd_out});
        fq.push_back(mk(8'h55, lcr_cur));
        wr(`ULC_OFS_LCR, {24'h0, lcr_cur});
        drain();
        $display("done: divisor commit");
        for (int i = 0; i < 8; i++) begin
            lcr_cur = fmt[i];
            wr(`ULC_OFS_LCR, {24'h0, lcr_cur});
            rd(`ULC_OFS_LCR, {24'h0, lcr_cur});
            for (int j = 0; j < 2; j++) tx(8'($urandom));
            drain();
        end
        $display("done: frame formats");
        wr(`ULC_OFS_CR, 32'h201);
        wr(`ULC_OFS_LCR, 32'h60);
        for (int j = 0; j < 2; j++) wr(`ULC_OFS_DATA, 32'ha0 + j);
        rd(`ULC_OFS_STATUS, 32'h6);
        lcr_cur = 8'h70;
        wr(`ULC_OFS_LCR, 32'h70);
        for (int j = 0; j < 2; j++) wr(`ULC_OFS_DATA, 32'hc0 + j);
        rd(`ULC_OFS_STATUS, 32'h2);
        for (int j = 0; j < 3; j++) fq.push_back(mk(j == 0 ? 8'ha0 : 8'(8'hbf + j), lcr_cur));
        wr(`ULC_OFS_CR, 32'h301);
        drain();
        $display("done: buffer modes");
        tx(8'h3c);
        tx(8'h5a);
        repeat (40) @(posedge core_clk_in);
        brk_on = 1'b1;
        wr(`ULC_OFS_LCR, 32'h71);
        repeat (400) @(posedge core_clk_in);
        chk_word("break line", 32'h0, {31'h0, txd_out});
        wr(`ULC_OFS_CR, 32'h201);
        wr(`ULC_OFS_LCR, 32'h70);
        repeat (4) @(posedge core_clk_in);
        brk_on = 1'b0;
        wr(`ULC_OFS_CR, 32'h301);
        drain();
        $display("done: break");
        rxc(8'h7e, 1'b0, 1'b0);
        rxc(8'h72, 1'b1, 1'b0);
        rxc(8'h50, 1'b0, 1'b1);
        rxc(8'hf2, 1'b0, 1'b0);
        rxc(8'hf6, 1'b1, 1'b0);
        rxc(8'h16, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk_in);
        $display("done: receive");
        results();
    end
endmodule : uart_line_control_tb
